// file: logic/tcp_timer_pwm.v
`timescale 1ns/1ps
`include "tcp_defs.vh"

module tcp_timer_pwm #(
   parameter WIDTH = 16 // Counter and value width
) (
   clock,
   rst_n,
   counter_halt,
   counter_reset,
   prescale_sel,
   ext_count_tick,
   period_modulo_value,
   ch_value_wdata,
   ch0_value_wr,
   ch1_value_wr,
   ch0_mode_field,
   ch1_mode_field,
   ch0_action_field,
   ch1_action_field,
   ch0_toggle_at_overflow,
   ch1_toggle_at_overflow,
   ch0_full_duty_bit,
   ch1_full_duty_bit,
   overflow_irq_en,
   ch0_irq_en,
   ch1_irq_en,
   overflow_flag_clear,
   ch0_flag_clear,
   ch1_flag_clear,
   counter_value,
   overflow_flag,
   ch0_flag,
   ch1_flag,
   overflow_irq,
   ch0_irq,
   ch1_irq,
   buffer_active_ch,
   ch0_value,
   ch1_value,
   ch0_pin,
   ch0_pin_oe,
   ch1_pin,
   ch1_pin_oe
);
   input  wire             clock;                  // 50 MHz bus clock
   input  wire             rst_n;                  // Async, active low
   input  wire             counter_halt;           // Stop counting
   input  wire             counter_reset;          // Pulse: clear count
   input  wire [2:0]       prescale_sel;           // Divide select
   input  wire             ext_count_tick;         // External tick
   input  wire [WIDTH-1:0] period_modulo_value;    // Last count
   input  wire [WIDTH-1:0] ch_value_wdata;         // Value write data
   input  wire             ch0_value_wr;           // Write ch0 value
   input  wire             ch1_value_wr;           // Write ch1 value
   input  wire [1:0]       ch0_mode_field;         // Link bit, low bit
   input  wire [1:0]       ch1_mode_field;         // Ch1 mode
   input  wire [1:0]       ch0_action_field;       // Ch0 compare act
   input  wire [1:0]       ch1_action_field;       // Ch1 compare act
   input  wire             ch0_toggle_at_overflow; // Ch0 overflow tgl
   input  wire             ch1_toggle_at_overflow; // Ch1 overflow tgl
   input  wire             ch0_full_duty_bit;      // Ch0 full duty
   input  wire             ch1_full_duty_bit;      // Ch1 full duty
   input  wire             overflow_irq_en;        // Overflow enable
   input  wire             ch0_irq_en;             // Ch0 enable
   input  wire             ch1_irq_en;             // Ch1 enable
   input  wire             overflow_flag_clear;    // Pulse: clear flag
   input  wire             ch0_flag_clear;         // Pulse: clear flag
   input  wire             ch1_flag_clear;         // Pulse: clear flag
   output reg  [WIDTH-1:0] counter_value;          // Running count
   output reg              overflow_flag;          // Sticky overflow
   output reg              ch0_flag;               // Sticky ch0 match
   output reg              ch1_flag;               // Sticky ch1 match
   output wire             overflow_irq;           // Overflow request
   output wire             ch0_irq;                // Ch0 request
   output wire             ch1_irq;                // Ch1 request
   output reg              buffer_active_ch;       // Linked owner
   output reg  [WIDTH-1:0] ch0_value;              // Ch0 value
   output reg  [WIDTH-1:0] ch1_value;              // Ch1 value
   output wire             ch0_pin;                // Ch0 pin level
   output wire             ch0_pin_oe;             // Ch0 pin drive
   output wire             ch1_pin;                // Ch1 pin level
   output wire             ch1_pin_oe;             // Ch1 pin drive

   // ==========================================================
   // Mode decode, shared by both channels
   // ==========================================================
   // Returns the effective mode; the link bit wins over the
   // low bit so 1:1 on channel 0 still means buffered
   function [1:0] tcp_mode_kind;
      input [1:0] field;
      input       can_link;
      begin
         if (field[`TCP_LINK_BIT] && can_link) begin
            tcp_mode_kind = `TCP_MODE_BUF;
         end else if (field != `TCP_MODE_CAPTURE) begin
            tcp_mode_kind = `TCP_MODE_UNBUF;
         end else begin
            tcp_mode_kind = `TCP_MODE_CAPTURE;
         end
      end
   endfunction

   wire [1:0] ch0_kind;  // Effective ch0 mode
   wire [1:0] ch1_kind;  // Effective ch1 mode
   wire       linked;    // Pair acts as one buffered channel
   wire       ch0_on;    // Ch0 drives compare output
   wire       ch1_on;    // Ch1 drives compare output

   assign ch0_kind = tcp_mode_kind(ch0_mode_field, 1'b1);
   assign ch1_kind = tcp_mode_kind(ch1_mode_field, 1'b0);
   assign linked   = (ch0_kind == `TCP_MODE_BUF);
   assign ch0_on   = (ch0_kind != `TCP_MODE_CAPTURE);
   // Ch1 control ignored while linked
   assign ch1_on   = !linked && (ch1_kind != `TCP_MODE_CAPTURE);

   // ==========================================================
   // Prescaler
   // ==========================================================
   reg  [5:0] pre_cnt;  // Free divider
   wire [5:0] pre_mask; // Low bits that must be all ones
   wire       tick;     // One counter step this cycle

   assign pre_mask = ~(`TCP_PRE_ONES << prescale_sel);
   // Code 000 gives a step every bus clock
   assign tick = (prescale_sel == `TCP_PS_EXT) ? ext_count_tick :
                 ((pre_cnt & pre_mask) == pre_mask);

   // Divider halts with the counter; a counter reset restarts it too
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt <= `TCP_PRE_RESET;
      end else if (counter_reset) begin
         pre_cnt <= `TCP_PRE_RESET;
      end else if (!counter_halt) begin
         pre_cnt <= pre_cnt + 6'h01;
      end
   end

   // ==========================================================
   // Counter and events
   // ==========================================================
   wire             step;       // Counter advances now
   wire             wrap;       // Count is at modulo value
   wire [WIDTH-1:0] next_count; // Count after this step
   wire             ovf_event;  // Rollover to zero
   wire [WIDTH-1:0] buf_value;  // Linked active value
   wire [WIDTH-1:0] cmp0_value; // Value ch0 unit compares
   wire             cmp0_event; // Ch0 (or linked) match
   wire             cmp1_event; // Ch1 match

   assign step       = tick && !counter_halt && !counter_reset;
   assign wrap       = (counter_value == period_modulo_value);
   // Modulo 00FF counts 0..255: 256 steps per period
   assign next_count = wrap ? `TCP_CNT_RESET :
                       counter_value + {{(WIDTH-1){1'b0}}, 1'b1};
   assign ovf_event  = step && wrap;
   assign buf_value  = buffer_active_ch ? ch1_value : ch0_value;
   assign cmp0_value = linked ? buf_value : ch0_value;
   // Equality only: a value already passed waits a period
   assign cmp0_event = step && (next_count == cmp0_value);
   assign cmp1_event = step && (next_count == ch1_value) &&
                       !linked;

   // Counter register
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         counter_value <= `TCP_CNT_RESET;
      end else if (counter_reset) begin
         counter_value <= `TCP_CNT_RESET;
      end else if (step) begin
         counter_value <= next_count;
      end
   end

   // ==========================================================
   // Channel value registers
   // ==========================================================
   // No holding stage: a write is live on the next compare,
   // so a late larger value can still match this period
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ch0_value <= `TCP_VAL_RESET;
         ch1_value <= `TCP_VAL_RESET;
      end else begin
         if (ch0_value_wr) begin
            ch0_value <= ch_value_wdata;
         end
         if (ch1_value_wr) begin
            ch1_value <= ch_value_wdata;
         end
      end
   end

   // ==========================================================
   // Buffered pair ownership
   // ==========================================================
   reg last_written; // Channel written most recently

   // Owner changes only at overflow, so a width written to the
   // non-owner channel never cuts into the running period;
   // a write to the owner channel is live at once
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         last_written     <= 1'b0;
         buffer_active_ch <= 1'b0;
      end else if (!linked) begin
         // Channel 0 owns the output when linking starts
         last_written     <= 1'b0;
         buffer_active_ch <= 1'b0;
      end else begin
         if (ch1_value_wr) begin
            last_written <= 1'b1;
         end else if (ch0_value_wr) begin
            last_written <= 1'b0;
         end
         if (ovf_event) begin
            buffer_active_ch <= last_written;
         end
      end
   end

   // ==========================================================
   // Sticky flags; a set in the clear cycle wins
   // ==========================================================
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag <= 1'b0;
         ch0_flag      <= 1'b0;
         ch1_flag      <= 1'b0;
      end else begin
         if (ovf_event) begin
            overflow_flag <= 1'b1;
         end else if (overflow_flag_clear) begin
            overflow_flag <= 1'b0;
         end
         // Only output compare channels flag matches
         if (cmp0_event && ch0_on) begin
            ch0_flag <= 1'b1;
         end else if (ch0_flag_clear) begin
            ch0_flag <= 1'b0;
         end
         if (cmp1_event && ch1_on) begin
            ch1_flag <= 1'b1;
         end else if (ch1_flag_clear) begin
            ch1_flag <= 1'b0;
         end
      end
   end

   // Requests follow the flags through their enables
   assign overflow_irq = overflow_flag && overflow_irq_en;
   assign ch0_irq      = ch0_flag && ch0_irq_en;
   assign ch1_irq      = ch1_flag && ch1_irq_en;

   // ==========================================================
   // Output stages
   // ==========================================================
   tcp_chan_out u_ch0 (
      .clock                (clock),
      .rst_n                (rst_n),
      .enable               (ch0_on),
      .overflow_event       (ovf_event),
      .compare_event        (cmp0_event),
      .compare_action_field (ch0_action_field),
      .toggle_at_overflow   (ch0_toggle_at_overflow),
      .full_duty_bit        (ch0_full_duty_bit),
      .pin                  (ch0_pin)
   );

   tcp_chan_out u_ch1 (
      .clock                (clock),
      .rst_n                (rst_n),
      .enable               (ch1_on),
      .overflow_event       (ovf_event),
      .compare_event        (cmp1_event),
      .compare_action_field (ch1_action_field),
      .toggle_at_overflow   (ch1_toggle_at_overflow),
      .full_duty_bit        (ch1_full_duty_bit),
      .pin                  (ch1_pin)
   );

   // Linked pair appears on pin 0 only; pin 1 left to port logic
   assign ch0_pin_oe = ch0_on;
   assign ch1_pin_oe = ch1_on;
endmodule // tcp_timer_pwm

// file: inc/tcp_defs.vh
// Function
// - Unbuffered write replaces active compare value directly
// - Equality compare only; passed values miss period
// - Channel interrupt request at ending compare match
// - Overflow interrupt request at counter rollover
// - Larger value written late still matches
// - Link bit pairs channels onto channel 0 pin
// - Linked: last written channel controls after overflow
// - Linked: channel 0 control governs; pin 1 freed
// - Buffered width change to non-owner channel starts at next period
// - Toggle at overflow sets PWM period
// - Pulse width spans overflow to compare match
// - Modulo 00FF, divide 000 gives 256 clocks
// - Value 0080 in 8-bit period gives half duty
// - Mode 0:1 unbuffered, 1:0 buffered
// - Link bit outranks ch0 mode low bit
// - Action 1:0 clears pin, 1:1 sets pin
// - Overflow toggle off with clear action gives constant zero duty
// - Full duty bit with toggle off gives constant high
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH

// ==========================================================
// Channel mode field codes
// ==========================================================
`define TCP_MODE_CAPTURE  2'b00
`define TCP_MODE_UNBUF    2'b01
`define TCP_MODE_BUF      2'b10
`define TCP_LINK_BIT      1

// ==========================================================
// Compare action field codes
// ==========================================================
`define TCP_ACT_NONE      2'b00
`define TCP_ACT_TOGGLE    2'b01
`define TCP_ACT_CLEAR     2'b10
`define TCP_ACT_SET       2'b11

// ==========================================================
// Prescaler and counter values
// ==========================================================
`define TCP_PS_EXT        3'b111
`define TCP_PRE_ONES      6'h3F
`define TCP_CNT_RESET     16'h0000
`define TCP_VAL_RESET     16'h0000
`define TCP_PRE_RESET     6'h00

`endif

// file: logic/tcp_chan_out.v
`timescale 1ns/1ps
`include "tcp_defs.vh"

module tcp_chan_out (
   clock,
   rst_n,
   enable,
   overflow_event,
   compare_event,
   compare_action_field,
   toggle_at_overflow,
   full_duty_bit,
   pin
);
   input  wire       clock;                // Bus clock
   input  wire       rst_n;                // Async reset, active low
   input  wire       enable;               // Output compare in use
   input  wire       overflow_event;       // Counter rolled over
   input  wire       compare_event;        // Counter hit value
   input  wire [1:0] compare_action_field; // Action on compare
   input  wire       toggle_at_overflow;   // Toggle pin at overflow
   input  wire       full_duty_bit;        // Hold pin high
   output reg        pin;                  // Pin level

   reg next_pin; // Level after this cycle
   reg mid_pin;  // Level after overflow step

   // ==========================================================
   // Pin update: overflow first, then compare action
   // ==========================================================
   always @* begin
      mid_pin  = pin;
      next_pin = pin;
      // Overflow toggle first so compare in same cycle wins
      if (enable && overflow_event && toggle_at_overflow) begin
         mid_pin = ~pin;
      end
      next_pin = mid_pin;
      if (enable && compare_event) begin
         case (compare_action_field)
            `TCP_ACT_TOGGLE: next_pin = ~mid_pin;
            `TCP_ACT_CLEAR:  next_pin = 1'b0;
            `TCP_ACT_SET:    next_pin = 1'b1;
            default:         next_pin = mid_pin;
         endcase
      end
      // Constant high overrides everything when not toggling
      if (enable && full_duty_bit && !toggle_at_overflow) begin
         next_pin = 1'b1;
      end
      // Without overflow toggles a clear compare parks low
   end

   // ==========================================================
   // Pin register
   // ==========================================================
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin <= 1'b0;
      end else begin
         pin <= next_pin;
      end
   end
endmodule // tcp_chan_out

// file: dv/tcp_timer_pwm_chk.sv
`timescale 1ns/1ps
`include "tcp_defs.vh"
// ==========================================================
// Port checker for the timer PWM block
// ==========================================================
module tcp_timer_pwm_chk #(
   parameter WIDTH = 16 // Count width
) (
   input logic             clock,
   input logic             rst_n,
   input logic             counter_halt,
   input logic             counter_reset,
   input logic [2:0]       prescale_sel,
   input logic [WIDTH-1:0] period_modulo_value,
   input logic             ch1_value_wr,
   input logic [1:0]       ch0_mode_field,
   input logic [1:0]       ch1_mode_field,
   input logic [1:0]       ch1_action_field,
   input logic             ch1_toggle_at_overflow,
   input logic             ch1_full_duty_bit,
   input logic             ch1_irq_en,
   input logic [WIDTH-1:0] counter_value,
   input logic             overflow_flag,
   input logic             ch1_flag,
   input logic             ch1_irq,
   input logic             buffer_active_ch,
   input logic [WIDTH-1:0] ch1_value,
   input logic             ch1_pin,
   input logic             ch0_pin_oe,
   input logic             ch1_pin_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Only the undivided rate is modelled; divided rates go vacuous
   wire             step;  // Count advances this edge
   wire             wrap;  // Rollover this edge
   wire [WIDTH-1:0] nxt;   // Count after this edge
   wire             live1; // Ch1 on its own pin
   wire             hit1;  // Ch1 match, no write racing
   assign step  = !counter_halt && !counter_reset && prescale_sel == 3'b000;
   assign wrap  = step && counter_value == period_modulo_value;
   assign nxt   = wrap ? {WIDTH{1'b0}} : counter_value + 1'b1;
   assign live1 = ch1_mode_field != 2'b00 && !ch0_mode_field[1];
   assign hit1  = step && live1 && nxt == ch1_value && !ch1_value_wr;
   // ==========================================================
   // Assertions
   // ==========================================================
   AST_COUNT: assert property (step |=> counter_value == $past(nxt))
      else $error("count did not step or wrap");
   AST_WRAP_FLAG: assert property (wrap |=> overflow_flag)
      else $error("no overflow flag at rollover");
   AST_OVF_TOGGLE: assert property (wrap && live1
      && ch1_toggle_at_overflow
      && ch1_value != 0 && !ch1_value_wr |=> ch1_pin != $past(ch1_pin))
      else $error("pin did not toggle at rollover");
   AST_CLEAR: assert property (hit1 && !ch1_full_duty_bit
      && ch1_action_field == `TCP_ACT_CLEAR |=> !ch1_pin)
      else $error("clear action missed");
   AST_SET: assert property (hit1 && ch1_action_field == `TCP_ACT_SET
      |=> ch1_pin)
      else $error("set action missed");
   AST_MATCH_FLAG: assert property (hit1 |=> ch1_flag)
      else $error("no channel flag at match");
   AST_IRQ: assert property (ch1_irq == (ch1_flag && ch1_irq_en))
      else $error("channel request not flag and enable");
   AST_LINK_OE: assert property (ch0_mode_field[1]
      |-> ch0_pin_oe && !ch1_pin_oe)
      else $error("linked pin drive wrong");
   AST_OWNER: assert property (ch0_mode_field[1]
      && counter_value != period_modulo_value |=> $stable(buffer_active_ch))
      else $error("owner changed away from rollover");
   AST_ZERO_DUTY: assert property (live1 && !ch1_toggle_at_overflow
      && !ch1_full_duty_bit && ch1_action_field == `TCP_ACT_CLEAR
      && !ch1_pin |=> !ch1_pin)
      else $error("zero duty output rose");
   AST_FULL_DUTY: assert property (live1 && !ch1_toggle_at_overflow
      && ch1_full_duty_bit |=> ch1_pin)
      else $error("full duty output low");
   // Main scenarios reached
   cover property (wrap);
   cover property (hit1);
   cover property ($rose(buffer_active_ch));
endmodule // tcp_timer_pwm_chk

bind tcp_timer_pwm tcp_timer_pwm_chk #(.WIDTH(WIDTH)) u_tcp_timer_pwm_chk (
   .clock, .rst_n, .counter_halt, .counter_reset, .prescale_sel,
   .period_modulo_value, .ch1_value_wr, .ch0_mode_field, .ch1_mode_field,
   .ch1_action_field, .ch1_toggle_at_overflow, .ch1_full_duty_bit,
   .ch1_irq_en, .counter_value, .overflow_flag, .ch1_flag, .ch1_irq,
   .buffer_active_ch, .ch1_value, .ch1_pin, .ch0_pin_oe, .ch1_pin_oe
);

// file: dv/tcp_timer_pwm_bench.sv
`timescale 1ns/1ps
`include "tcp_defs.vh"
`define CHK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      n_fail++; \
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp); \
   end \
end
// ==========================================================
// Bench for the timer PWM block
// ==========================================================
module tcp_timer_pwm_bench;
   logic        clock, rst_n, counter_halt, counter_reset, ext_count_tick;
   logic [2:0]  prescale_sel;
   logic [15:0] period_modulo_value, ch_value_wdata;
   logic        ch0_value_wr, ch1_value_wr;
   logic [1:0]  ch0_mode_field, ch1_mode_field;
   logic [1:0]  ch0_action_field, ch1_action_field;
   logic        ch0_toggle_at_overflow, ch1_toggle_at_overflow;
   logic        ch0_full_duty_bit, ch1_full_duty_bit;
   logic        overflow_irq_en, ch0_irq_en, ch1_irq_en;
   logic        overflow_flag_clear, ch0_flag_clear, ch1_flag_clear;
   logic [15:0] counter_value, ch0_value, ch1_value;
   logic        overflow_flag, ch0_flag, ch1_flag;
   logic        overflow_irq, ch0_irq, ch1_irq, buffer_active_ch;
   logic        ch0_pin, ch0_pin_oe, ch1_pin, ch1_pin_oe;
   int          comparisons, n_fail, hi, per; // Tallies, measurements

   tcp_timer_pwm u_tcp_timer_pwm (
      .clock, .rst_n, .counter_halt, .counter_reset, .prescale_sel,
      .ext_count_tick, .period_modulo_value, .ch_value_wdata,
      .ch0_value_wr, .ch1_value_wr, .ch0_mode_field, .ch1_mode_field,
      .ch0_action_field, .ch1_action_field, .ch0_toggle_at_overflow,
      .ch1_toggle_at_overflow, .ch0_full_duty_bit, .ch1_full_duty_bit,
      .overflow_irq_en, .ch0_irq_en, .ch1_irq_en, .overflow_flag_clear,
      .ch0_flag_clear, .ch1_flag_clear, .counter_value, .overflow_flag,
      .ch0_flag, .ch1_flag, .overflow_irq, .ch0_irq, .ch1_irq,
      .buffer_active_ch, .ch0_value, .ch1_value, .ch0_pin, .ch0_pin_oe,
      .ch1_pin, .ch1_pin_oe
   );

   // 50 MHz bus clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // ==========================================================
   // Access tasks
   // ==========================================================
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // One-cycle value write strobe
   task automatic wr(input bit ch, input logic [15:0] d);
      @(posedge clock);
      ch_value_wdata <= d;
      if (ch) ch1_value_wr <= 1'b1;
      else ch0_value_wr <= 1'b1;
      @(posedge clock);
      ch0_value_wr <= 1'b0;
      ch1_value_wr <= 1'b0;
   endtask
   // Clear pulses on overflow and ch1 flags
   task automatic clr();
      @(posedge clock);
      {overflow_flag_clear, ch1_flag_clear} <= 2'b11;
      @(posedge clock);
      {overflow_flag_clear, ch1_flag_clear} <= 2'b00;
   endtask
   // Bounded wait for a count; a miss shows as a mismatch
   task automatic at_cnt(input logic [15:0] v);
      int k;
      k = 0;
      do begin @(negedge clock); k++; end
      while (counter_value !== v && k < 700);
      `CHK(counter_value, v)
   endtask
   function automatic logic pin(input bit s);
      return s ? ch1_pin : ch0_pin;
   endfunction
   // High time and period between two rising pin edges
   task automatic meas(input bit s, output int h, output int p);
      h = 0;
      p = 0;
      @(negedge clock);
      while (pin(s) !== 1'b0 && p < 700) begin @(negedge clock); p++; end
      while (pin(s) !== 1'b1 && p < 1400) begin @(negedge clock); p++; end
      p = 0;
      while (pin(s) === 1'b1 && p < 700) begin h++; p++; @(negedge clock); end
      while (pin(s) !== 1'b1 && p < 700) begin p++; @(negedge clock); end
   endtask
   // High samples of ch1 over one 8-bit period
   task automatic hold(output int h);
      h = 0;
      repeat (256) begin @(negedge clock); h += (ch1_pin === 1'b1); end
   endtask
   task automatic complete_run();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      comparisons = 0;
      n_fail = 0;
      {counter_reset, ext_count_tick, prescale_sel, ch_value_wdata} = '0;
      {ch0_value_wr, ch1_value_wr, ch0_mode_field, ch1_mode_field} = '0;
      {ch0_action_field, ch1_action_field, ch0_full_duty_bit} = '0;
      {ch0_toggle_at_overflow, ch1_toggle_at_overflow} = '0;
      {ch1_full_duty_bit, overflow_irq_en, ch0_irq_en, ch1_irq_en} = '0;
      {overflow_flag_clear, ch0_flag_clear, ch1_flag_clear} = '0;
      period_modulo_value = 16'h0000;
      counter_halt = 1'b1; // Halted out of reset, as software expects
      rst_n = 1'b0;
      cyc(16);
      rst_n <= 1'b1;
      @(negedge clock);
      `CHK({counter_value, overflow_flag, ch1_flag, ch1_pin}, 19'h0_0000)
      // Setup order: halt, clear, period, width, mode, then run
      cyc(1);
      counter_reset <= 1'b1;
      cyc(1);
      counter_reset <= 1'b0;
      period_modulo_value <= 16'h00FF;
      wr(1, 16'h0080);
      ch1_mode_field <= `TCP_MODE_UNBUF;
      ch1_toggle_at_overflow <= 1'b1;
      ch1_action_field <= `TCP_ACT_CLEAR;
      cyc(1);
      counter_halt <= 1'b0;
      meas(1, hi, per);
      `CHK(per, 256)
      `CHK(hi, 128)
      // Requests follow flag and enable
      cyc(1);
      {ch1_irq_en, overflow_irq_en} <= 2'b11;
      at_cnt(16'h0010);
      `CHK({ch1_irq, overflow_irq}, 2'b11)
      clr();
      @(negedge clock);
      `CHK({ch1_flag, overflow_flag, ch1_irq}, 3'b000)
      at_cnt(16'h0081);
      `CHK({ch1_irq, overflow_irq}, 2'b10)
      at_cnt(16'h0001);
      `CHK(overflow_irq, 1'b1)
      // Unbuffered writes take effect at once
      at_cnt(16'h0082);
      clr();
      wr(1, 16'h0040);
      at_cnt(16'h0041);
      `CHK({ch1_pin, ch1_flag}, 2'b01)
      `CHK(ch1_value, 16'h0040)
      clr();
      wr(1, 16'h0090);
      at_cnt(16'h0091);
      `CHK(ch1_flag, 1'b1)
      // A value already passed gives no compare this period
      at_cnt(16'h0020);
      wr(1, 16'h0010);
      at_cnt(16'h00FE);
      `CHK(ch1_pin, 1'b1)
      // Set action gives an active-low pulse
      wr(1, 16'h0040);
      ch1_action_field <= `TCP_ACT_SET;
      cyc(520);
      meas(1, hi, per);
      `CHK(hi, 192)
      // Overflow toggle off: constant low, then constant high
      cyc(1);
      ch1_action_field <= `TCP_ACT_CLEAR;
      ch1_toggle_at_overflow <= 1'b0;
      cyc(300);
      hold(hi);
      `CHK(hi, 0)
      cyc(1);
      ch1_full_duty_bit <= 1'b1;
      cyc(2);
      hold(hi);
      `CHK(hi, 256)
      // Linked pair with both mode bits set
      cyc(1);
      ch1_full_duty_bit <= 1'b0;
      ch1_toggle_at_overflow <= 1'b1;
      wr(0, 16'h0040);
      ch0_action_field <= `TCP_ACT_CLEAR;
      ch0_toggle_at_overflow <= 1'b1;
      ch0_mode_field <= 2'b11;
      ch0_irq_en <= 1'b1;
      @(negedge clock);
      `CHK({ch0_pin_oe, ch1_pin_oe, buffer_active_ch}, 3'b100)
      meas(0, hi, per);
      `CHK(hi, 64)
      wr(1, 16'h00C0);
      at_cnt(16'h0041);
      `CHK({ch0_pin, buffer_active_ch}, 2'b00)
      `CHK({ch0_flag, ch0_irq, ch1_value}, 18'h3_00C0)
      meas(0, hi, per);
      `CHK(hi, 192)
      `CHK(buffer_active_ch, 1'b1)
      cyc(1);
      ch0_mode_field <= `TCP_MODE_BUF;
      wr(0, 16'h0020);
      meas(0, hi, per);
      `CHK(hi, 32)
      `CHK(ch0_value, 16'h0020)
      // Divide by two doubles the period
      cyc(1);
      prescale_sel <= 3'b001;
      meas(0, hi, per);
      `CHK(per, 512)
      complete_run();
   end

   // Hang guard, well beyond the few thousand cycles needed
   initial begin
      cyc(30000);
      n_fail++;
      complete_run();
   end
endmodule // tcp_timer_pwm_bench
